// ===== hdl/half_bridge_spi_command_word.v
// Serial command word slave of a six-channel half-bridge driver
`timescale 1ns/1ps
`default_nettype none
`include "bridge_consts.vh"
module half_bridge_spi_command_word #(
  parameter NUM_BRIDGES = 6
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire chip_select_n_i,
  input wire sclk_i,
  input wire sdi_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  input wire [15:0] status_word0_i,
  input wire [15:0] status_word1_i,
  output reg status_clear_o,
  output reg status_clear_addr_o,
  output reg openload_shutdown_enable_o,
  output reg [NUM_BRIDGES-1:0] high_side_switch_o,
  output reg [NUM_BRIDGES-1:0] low_side_switch_o,
  output reg [15:0] bridge_command_word_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; pins are foreign to ref_clk_i
  reg [1:0] cs_sync_q;
  reg [1:0] sck_sync_q;
  reg [1:0] sdi_sync_q;
  reg cs_prev_q;
  reg sck_prev_q;
  wire cs_fall;
  wire cs_rise;
  wire selected;
  wire sck_rise;
  wire sck_fall;
  wire sdi_bit;

  // Chip select resets to its idle level, else a false frame follows reset
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync_q <= `CS_SYNC_RESET;
    end else begin
      cs_sync_q <= {cs_sync_q[0], chip_select_n_i};
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_sync_q <= `SCK_SYNC_RESET;
    end else begin
      sck_sync_q <= {sck_sync_q[0], sclk_i};
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdi_sync_q <= `SDI_SYNC_RESET;
    end else begin
      sdi_sync_q <= {sdi_sync_q[0], sdi_i};
    end
  end

  // Delayed copies read only the second stage
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_prev_q <= 1'h1;
      sck_prev_q <= 1'h0;
    end else begin
      cs_prev_q <= cs_sync_q[1];
      sck_prev_q <= sck_sync_q[1];
    end
  end

  function edge_up;
    input now_level;
    input old_level;
    begin
      edge_up = now_level & ~old_level;
    end
  endfunction

  function edge_down;
    input now_level;
    input old_level;
    begin
      edge_down = ~now_level & old_level;
    end
  endfunction

  assign cs_fall = edge_down(cs_sync_q[1], cs_prev_q);
  assign cs_rise = edge_up(cs_sync_q[1], cs_prev_q);
  assign selected = ~cs_sync_q[1];
  // Master shifts on rising clock, data valid on falling edge
  assign sck_rise = edge_up(sck_sync_q[1], sck_prev_q);
  assign sck_fall = edge_down(sck_sync_q[1], sck_prev_q);
  // Data sits two stages deep, in step with its clock edge
  assign sdi_bit = sdi_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and serial output
  reg [15:0] shift_q;
  reg [15:0] cmd_q;
  reg addr_q;
  reg clear_pend_q;
  wire [15:0] status_sel;

  assign status_sel = addr_q ? status_word1_i : status_word0_i;

  // Plain shift: input bits leave on the output 16 bits later
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= `CMD_RESET;
    end else if (cs_fall) begin
      // Status of the previously addressed register is loaded
      shift_q <= status_sel;
    end else if (selected && sck_fall) begin
      shift_q <= {shift_q[`WORD_BITS-2:0], sdi_bit};
    end
  end

  // Output bit changes on rising clock, stands through the falling one
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdo_o <= 1'h0;
    end else if (cs_fall) begin
      sdo_o <= status_sel[`WORD_BITS-1];
    end else if (selected && sck_rise) begin
      sdo_o <= shift_q[`WORD_BITS-1];
    end
  end

  // Released at frame end so other slaves may drive the line
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdo_oe_o <= 1'h0;
    end else if (cs_fall) begin
      sdo_oe_o <= 1'h1;
    end else if (cs_rise) begin
      sdo_oe_o <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied word and read-and-clear command

  // Word applied only at end of frame; held until next one
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= `CMD_RESET;
    end else if (cs_rise) begin
      cmd_q <= shift_q;
    end
  end

  // Bit 14 picks the status register for the next frame
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q <= `STATUS_ADDR_RESET;
    end else if (cs_rise) begin
      addr_q <= shift_q[`BIT_GROUP_SEL];
    end
  end

  // Request waits a frame: it clears the register read back next
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_pend_q <= 1'h0;
    end else if (cs_rise) begin
      clear_pend_q <= shift_q[`BIT_CLEAR_REQ];
    end
  end

  // One-cycle clear at chip-select rise
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_clear_o <= 1'h0;
      status_clear_addr_o <= 1'h0;
    end else begin
      status_clear_o <= cs_rise & clear_pend_q;
      if (cs_rise) begin
        status_clear_addr_o <= addr_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridge drive from the applied word

  // Enabled bridge follows side select, else both off
  function switch_on;
    input enable_bit;
    input side_bit;
    input want_high;
    begin
      switch_on = enable_bit & (want_high ? side_bit : ~side_bit);
    end
  endfunction

  integer i;
  integer j;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_side_switch_o <= {NUM_BRIDGES{1'h0}};
    end else begin
      for (i = 0; i < NUM_BRIDGES; i = i + 1) begin
        high_side_switch_o[i] <= switch_on(cmd_q[`BIT_ENABLE_LSB+i],
          cmd_q[`BIT_SIDE_LSB+i], 1'h1);
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_side_switch_o <= {NUM_BRIDGES{1'h0}};
    end else begin
      for (j = 0; j < NUM_BRIDGES; j = j + 1) begin
        low_side_switch_o[j] <= switch_on(cmd_q[`BIT_ENABLE_LSB+j],
          cmd_q[`BIT_SIDE_LSB+j], 1'h0);
      end
    end
  end

  // Only arms the shutdown; fault detection lives elsewhere
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      openload_shutdown_enable_o <= 1'h0;
    end else begin
      openload_shutdown_enable_o <= cmd_q[`BIT_OPENLOAD_SD];
    end
  end

  // Word passed as received; bit 0 is the master's to keep low
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bridge_command_word_o <= `CMD_RESET;
    end else begin
      bridge_command_word_o <= cmd_q;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/bridge_consts.vh
// Constants for the half-bridge serial command path
// Overview of operation
// - Apply received word at chip-select rising edge
// - Address in one frame, data next frame
// - Status address zero after reset
// - Clear request acts on next transmission
// - Address plus clear form read-and-clear command
// - Bit 15 high clears addressed error bits
// - Bit 13 enables open-load shutdown
// - Bits 12..7 enable bridges six..one
// - Bits 6..1 select high or low side
// - Plain shift register, daisy-chainable
// - Sixteen bits, MSB first, full duplex
// - Capture status at chip-select falling edge
// - Applied word holds until replaced or reset
`ifndef BRIDGE_CONSTS_VH
`define BRIDGE_CONSTS_VH
`define WORD_BITS 16
`define BIT_CLEAR_REQ 15
`define BIT_GROUP_SEL 14
`define BIT_OPENLOAD_SD 13
`define BIT_ENABLE_LSB 7
`define BIT_SIDE_LSB 1
`define CMD_RESET 16'h0000
`define STATUS_ADDR_RESET 1'h0
`define CS_SYNC_RESET 2'h3
`define SCK_SYNC_RESET 2'h0
`define SDI_SYNC_RESET 2'h0
`endif

// ===== test/bridge_chk_assertions.sv
// Checker of the bridge command path
`timescale 1ns/1ps
`default_nettype none
module bridge_chk #(parameter NUM_BRIDGES = 6) (
  input wire logic ref_clk_i, rst_n_i, chip_select_n_i, sdo_oe_o, status_clear_o,
  input wire logic [NUM_BRIDGES-1:0] high_side_switch_o, low_side_switch_o,
  input wire logic [15:0] bridge_command_word_o
);
  wire cs = chip_select_n_i;
  wire [15:0] w = bridge_command_word_o;
  wire [NUM_BRIDGES-1:0] h = high_side_switch_o, l = low_side_switch_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  word_hold_a: assert property (!cs [*8] |-> $stable(w)) else $error("word");
  sdo_on_a: assert property ($fell(cs) |-> ##[2:5] sdo_oe_o) else $error("drive");
  sdo_off_a: assert property ($rose(cs) |-> ##[2:5] !sdo_oe_o) else $error("release");
  clear_single_a: assert property (status_clear_o |=> !status_clear_o) else $error("clear");
  clear_end_a: assert property (status_clear_o |-> cs) else $error("early");
  enable_map_a: assert property ($stable({w, h, l}) |-> (h | l) == w[12:7]) else $error("en");
  side_map_a: assert property ($stable({w, h, l}) |-> h == (w[12:7] & w[6:1])) else $error("hs");
  cross_off_a: assert property ((h & l) == 0) else $error("both");
  clear_c: cover property (status_clear_o);
  drive_c: cover property ($rose(sdo_oe_o));
  switch_c: cover property ($changed(h));
endmodule
bind half_bridge_spi_command_word bridge_chk #(.NUM_BRIDGES(NUM_BRIDGES)) u_bridge_chk (.*);
`default_nettype wire

// ===== test/spi_master.sv
// Serial master model
`timescale 1ns/1ps
`default_nettype none
module spi_master (
  input wire logic clk_i, sdo_i,
  output var logic cs_n_o = 1'b1, sclk_o = 1'b0, sdi_o = 1'b0
);
  task automatic half;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_i);
    #1;
    cs_n_o = 1'b0; // Clock low at select edges
    half();
    half();
    for (int i = 15; i >= 0; i--) begin // MSB first
      sdi_o = tx[i] & (i != 0);
      sclk_o = 1'b1;
      half();
      rx[i] = sdo_i; // Valid at the falling edge
      sclk_o = 1'b0;
      half();
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Idle line never repeats
    half();
  endtask
endmodule
`default_nettype wire

// ===== test/half_bridge_spi_command_word_test.sv
// Bench of the bridge command path
`timescale 1ns/1ps
`default_nettype none
module half_bridge_spi_command_word_test;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, chip_select_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_o;
  logic status_clear_o, status_clear_addr_o, openload_shutdown_enable_o;
  logic [15:0] status_word0_i = 16'hA5C3, status_word1_i = 16'h3C5A, bridge_command_word_o, rx;
  logic [5:0] high_side_switch_o, low_side_switch_o;
  logic [1:0] clr;
  int errors = 0, total_checks = 0;
  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (status_clear_o) clr <= {1'b1, status_clear_addr_o};
  spi_master u_spi_master (.clk_i(ref_clk_i), .sdo_i(sdo_o), .cs_n_o(chip_select_n_i),
    .sclk_o(sclk_i), .sdi_o(sdi_i));
  half_bridge_spi_command_word u_half_bridge_spi_command_word (.*);
  task automatic chk(string n, logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic xfer(logic [15:0] tx, e, s, f);
    clr = 2'h0;
    u_spi_master.frame(tx, rx);
    repeat (4) @(posedge ref_clk_i);
    chk("status", e, rx);
    chk("word", tx, bridge_command_word_o);
    chk("switch", s, {4'h0, high_side_switch_o, low_side_switch_o});
    chk("flags", f, {13'h0000, openload_shutdown_enable_o, clr});
    chk("release", 16'h0000, {15'h0000, sdo_oe_o});
    $display("done %h", tx);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("reset", 16'h0000, bridge_command_word_o);
    xfer(16'hF5E4, status_word0_i, 16'h0889, 16'h0004);
    xfer(16'h0000, status_word1_i, 16'h0000, 16'h0003);
    xfer(16'h0000, status_word0_i, 16'h0000, 16'h0000);
    close_out();
  end
  initial begin
    #20000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
